// ===== rtl/pew_pkg.sv
// Purpose: Shared constants and types for the parallel EEPROM host controller
// Assumes: 125 MHz mclk_i, one clock domain
// Notes: Pin timing counts derive from printed times and the clock period
package pew_pkg;
  // ==========================================================
  // Geometry
  localparam int ADDR_W = 11;              // Byte address width
  localparam int DATA_W = 8;               // Data width
  localparam int PAGE_LOW_W = 4;           // Low address bits that vary inside a page
  localparam int PAGE_MAX = 16;            // Bytes per page
  localparam int POLL_BIT = 7;             // Completion polling bit
  // ==========================================================
  // Timing
  localparam int CLK_PS = 8000;            // Clock period in ps
  localparam int STROBE_NS = 120;          // Strobe low width, above 100 ns pulse minimum
  localparam int SETUP_NS = 16;            // Address and OE setup around strobes
  localparam int READ_NS = 200;            // Read access allowance
  localparam int WINDOW_US = 20;           // Page byte load window (longest)
  localparam int WINDOW_MARGIN_US = 2;     // Margin kept below the window
  localparam int PWRUP_MS = 5;             // Power-up to first write
  localparam int WRITE_TO_MS = 10;         // Longest write cycle before giving up
  localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int SETUP_CYC = (SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int READ_CYC = (READ_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int WINDOW_CYC = ((WINDOW_US - WINDOW_MARGIN_US) * 1000000) / CLK_PS;
  // Scaled through whole ns so that no intermediate product leaves 32 bits
  localparam int PWRUP_CYC = (PWRUP_MS * 1000000) / (CLK_PS / 1000);
  localparam int WRITE_TO_CYC = (WRITE_TO_MS * 1000000) / (CLK_PS / 1000);
  localparam int CNT_W = 24;               // Width of the shared timer
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PEW_CMD_READ = 2'h0,                   // Single byte read
    PEW_CMD_WRITE = 2'h1,                  // Byte load, page continues if next is a write to the same page, page not full, in the window
    PEW_CMD_POLL = 2'h2                    // Wait for programming completion
  } pew_cmd_t;

  typedef struct packed {
    pew_cmd_t cmd;                         // Operation
    logic [ADDR_W-1:0] addr;               // Byte address
    logic [DATA_W-1:0] data;               // Write data
  } pew_req_t;

  typedef struct packed {
    logic cs_n;                            // Chip select, low active
    logic oe_n;                            // Output enable, low active
    logic we_n;                            // Write enable, low active
    logic [ADDR_W-1:0] addr;               // Byte address pins
    logic [DATA_W-1:0] dout;               // Data pin drive value
    logic dout_oe_n;                       // Data pin drive enable, low drives
  } pew_pins_t;
endpackage : pew_pkg

// ===== rtl/pew_timer.sv
// Purpose: Down counter that times the power-up wait and the strobe phases
// Assumes: Same clock and reset as the controller
// Notes: done_o is high while the count is zero
`timescale 1ns/100ps
module pew_timer (
  input wire logic mclk_i,                          // Clock
  input wire logic rst_n_i,                         // Synchronised reset, low active
  input wire logic load_i,                          // Load a new count
  input wire logic [pew_pkg::CNT_W-1:0] count_i,    // Count to load
  output logic done_o                               // Count has expired
);
  logic [pew_pkg::CNT_W-1:0] cnt_ff;                // Remaining cycles
  logic [pew_pkg::CNT_W-1:0] nxt_cnt;               // Next count
  logic zero;                                       // Count is zero

  assign zero = (cnt_ff == '0);
  assign nxt_cnt = load_i ? count_i : (zero ? cnt_ff : cnt_ff - 1'b1);
  assign done_o = zero;

  // ==========================================================
  // Counter register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : pew_timer

// ===== rtl/pew_host.sv
// Purpose: Host controller driving a parallel byte EEPROM through its pins
// Assumes: Requests arrive from logic on mclk_i; data pins are sampled through two flops
// Notes: Back-to-back writes in one page are merged into a page write
//
// Notes on behaviour
// - Chip select low for every access
// - Write strobes CS and WE low, OE high
// - Page loads keep upper address bits fixed
// - Following writes extend the page
// - Next WE fall within window
// - Strobes held inactive during reset
// - Chip select as primary device select
// - First write waits after power-up
`timescale 1ns/100ps
module pew_host #(
  parameter int PWRUP_CYC = pew_pkg::PWRUP_CYC      // Start-up wait in cycles
) (
  input wire logic mclk_i,                          // 125 MHz clock
  input wire logic rstn_i,                          // Async reset, low active
  input wire logic req_valid_i,                     // Request present
  input wire pew_pkg::pew_req_t req_i,              // Request
  output logic req_ready_o,                         // Request taken this cycle
  output logic rsp_valid_o,                         // Response pulse
  output logic [pew_pkg::DATA_W-1:0] rsp_data_o,    // Read data
  output logic rsp_timeout_o,                       // Poll gave up
  output logic busy_o,                              // Start-up, access, page or programming pending
  output pew_pkg::pew_pins_t pins_o,                // Memory pins
  input wire logic [pew_pkg::DATA_W-1:0] data_pins_i // Data pins as seen
);
  // ==========================================================
  // States
  typedef enum logic [2:0] {
    ST_PWRUP = 3'h0, ST_IDLE = 3'h1, ST_SETUP = 3'h3, ST_STROBE = 3'h2,
    ST_HOLD = 3'h6, ST_PAGE = 3'h7, ST_READ = 3'h5, ST_PROG = 3'h4
  } pew_state_t;

  pew_state_t state_ff, nxt_state;                  // Sequencer state
  logic [1:0] rst_sync_ff;                          // Reset release synchroniser
  logic rst_n;                                      // Synchronised reset
  logic [pew_pkg::DATA_W-1:0] din_s1_ff, din_s2_ff; // Data pin synchroniser
  pew_pkg::pew_req_t cur_ff;                        // Request in progress
  pew_pkg::pew_pins_t pins_ff, nxt_pins;            // Pin registers
  logic [pew_pkg::ADDR_W-1:0] last_addr_ff;         // Last address written
  logic [pew_pkg::DATA_W-1:0] last_data_ff;         // Last data written
  logic [4:0] loads_ff;                             // Bytes loaded in current page
  logic page_open_ff;                               // A page is being loaded
  logic [pew_pkg::CNT_W-1:0] window_ff;             // Cycles since last WE fall
  logic [pew_pkg::CNT_W-1:0] tmo_ff;                // Poll time spent
  logic take, t_load, t_done;                       // Handshake and timer control
  logic [pew_pkg::CNT_W-1:0] t_count;               // Timer load value
  logic same_page, page_full, window_ok, is_write;  // Page decisions
  logic poll_done, poll_tmo;                        // Poll results
  logic rsp_v_ff, rsp_t_ff;                         // Response flags
  logic busy_ff;                                    // Registered busy level
  logic [pew_pkg::DATA_W-1:0] rsp_d_ff;             // Response data

  // ==========================================================
  // Reset release through two flops
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ==========================================================
  // Data pins come from outside, two flops before use
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      din_s1_ff <= 8'h00;
      din_s2_ff <= 8'h00;
    end else begin
      din_s1_ff <= data_pins_i;
      din_s2_ff <= din_s1_ff;
    end
  end

  // ==========================================================
  // Decisions
  assign is_write = (req_i.cmd == pew_pkg::PEW_CMD_WRITE);
  assign same_page = (req_i.addr[pew_pkg::ADDR_W-1:pew_pkg::PAGE_LOW_W] ==
                      last_addr_ff[pew_pkg::ADDR_W-1:pew_pkg::PAGE_LOW_W]);
  assign page_full = (loads_ff == 5'(pew_pkg::PAGE_MAX));
  assign window_ok = (window_ff < 24'(pew_pkg::WINDOW_CYC));
  // A page request outside the rules is held until programming is over
  assign take = req_valid_i && (
      (state_ff == ST_IDLE) ||
      (state_ff == ST_PAGE && is_write && same_page && !page_full && window_ok));
  assign poll_done = (din_s2_ff[pew_pkg::POLL_BIT] == last_data_ff[pew_pkg::POLL_BIT]);
  assign poll_tmo = (tmo_ff >= 24'(pew_pkg::WRITE_TO_CYC));

  // ==========================================================
  // Sequencer and pin values
  always_comb begin
    nxt_state = state_ff;
    nxt_pins = pins_ff;
    t_load = 1'b0;
    t_count = '0;
    unique case (state_ff)
      ST_PWRUP: begin
        // The reset marker in loads_ff flags the first cycle, which starts the wait
        if (loads_ff == 5'h1F) begin
          t_load = 1'b1;
          t_count = 24'(PWRUP_CYC);
        end else if (t_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE, ST_PAGE: begin
        if (take) begin
          nxt_pins.addr = req_i.addr;
          nxt_pins.dout = req_i.data;
          nxt_pins.dout_oe_n = !is_write;
          nxt_pins.cs_n = 1'b0;
          t_load = 1'b1;
          t_count = 24'(pew_pkg::SETUP_CYC);
          nxt_state = ST_SETUP;
        end else if (state_ff == ST_PAGE && !req_valid_i && !window_ok) begin
          nxt_state = ST_PROG;
        end else if (state_ff == ST_PAGE && req_valid_i) begin
          nxt_state = ST_PROG;
        end else if (state_ff == ST_IDLE) begin
          nxt_pins.cs_n = 1'b1;
        end
      end
      ST_SETUP: begin
        if (t_done) begin
          if (cur_ff.cmd == pew_pkg::PEW_CMD_WRITE) begin
            nxt_pins.we_n = 1'b0;
            t_count = 24'(pew_pkg::STROBE_CYC);
            nxt_state = ST_STROBE;
          end else begin
            nxt_pins.oe_n = 1'b0;
            t_count = 24'(pew_pkg::READ_CYC);
            nxt_state = ST_READ;
          end
          t_load = 1'b1;
        end
      end
      ST_STROBE: begin
        if (t_done) begin
          nxt_pins.we_n = 1'b1;
          t_load = 1'b1;
          t_count = 24'(pew_pkg::SETUP_CYC);
          nxt_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (t_done) begin
          nxt_pins.dout_oe_n = 1'b1;
          nxt_state = ST_PAGE;
        end
      end
      ST_READ: begin
        if (t_done) begin
          nxt_pins.oe_n = 1'b1;
          nxt_pins.cs_n = 1'b1;
          nxt_state = (cur_ff.cmd == pew_pkg::PEW_CMD_POLL) ? ST_PROG : ST_IDLE;
        end
      end
      ST_PROG: begin
        // Poll the last byte; settle time lets the synchroniser catch up
        if (cur_ff.cmd == pew_pkg::PEW_CMD_POLL && poll_done && pins_ff.cs_n) begin
          nxt_state = ST_IDLE;
        end else if (poll_tmo) begin
          // Give up and deselect, so idle never leaves the device selected
          nxt_pins.cs_n = 1'b1;
          nxt_state = ST_IDLE;
        end else if (t_done) begin
          nxt_pins.addr = last_addr_ff;
          nxt_pins.cs_n = 1'b0;
          t_load = 1'b1;
          t_count = 24'(pew_pkg::SETUP_CYC);
          nxt_state = ST_SETUP;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Shared timer
  pew_timer u_timer (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .load_i(t_load),
    .count_i(t_count),
    .done_o(t_done)
  );

  // ==========================================================
  // State, pins and page bookkeeping
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_PWRUP;
      pins_ff <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dout: '0, dout_oe_n: 1'b1};
      cur_ff <= '0;
      last_addr_ff <= '0;
      last_data_ff <= '0;
      loads_ff <= 5'h1F;
      page_open_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pins_ff <= nxt_pins;
      if (take) begin
        cur_ff <= req_i;
      end else if (state_ff == ST_PAGE && nxt_state == ST_PROG) begin
        cur_ff.cmd <= pew_pkg::PEW_CMD_POLL;
      end
      if (take && is_write) begin
        last_addr_ff <= req_i.addr;
        last_data_ff <= req_i.data;
        loads_ff <= page_open_ff ? loads_ff + 5'h01 : 5'h01;
        page_open_ff <= 1'b1;
      end else if (nxt_state == ST_PROG) begin
        page_open_ff <= 1'b0;
      end else if (state_ff == ST_PWRUP) begin
        loads_ff <= 5'h00;
      end
    end
  end

  // ==========================================================
  // Window and poll timers
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      window_ff <= '0;
      tmo_ff <= '0;
    end else begin
      window_ff <= (pins_ff.we_n && !nxt_pins.we_n) ? '0 : window_ff + 24'h1;
      tmo_ff <= (state_ff == ST_PROG || cur_ff.cmd == pew_pkg::PEW_CMD_POLL) ?
                tmo_ff + 24'h1 : '0;
    end
  end

  // ==========================================================
  // Responses
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rsp_v_ff <= 1'b0;
      rsp_t_ff <= 1'b0;
      rsp_d_ff <= 8'h00;
      busy_ff <= 1'b1;
    end else begin
      busy_ff <= (nxt_state != ST_IDLE);
      rsp_v_ff <= (state_ff == ST_READ && t_done && cur_ff.cmd == pew_pkg::PEW_CMD_READ) ||
                  (state_ff == ST_PROG && nxt_state == ST_IDLE);
      rsp_t_ff <= (state_ff == ST_PROG && nxt_state == ST_IDLE && poll_tmo);
      if (state_ff == ST_READ && t_done) begin
        rsp_d_ff <= din_s2_ff;
      end
    end
  end

  assign req_ready_o = take;
  assign rsp_valid_o = rsp_v_ff;
  assign rsp_data_o = rsp_d_ff;
  assign rsp_timeout_o = rsp_t_ff;
  assign busy_o = busy_ff;
  assign pins_o = pins_ff;
endmodule : pew_host

// ===== dv/pew_host_props.sv
// Purpose: Pin protocol checks for the EEPROM host
// Assumes: One clock, bound to the top module
// Notes: A poll read ends the tracked page
`timescale 1ns/100ps
module pew_host_props #(parameter int PWRUP_CYC = pew_pkg::PWRUP_CYC) (
  input wire logic mclk_i, // Clock
  input wire logic rstn_i, // Reset, low active
  input wire logic req_valid_i, // Request present
  input wire logic req_ready_o, // Request taken
  input wire logic rsp_valid_o, // Response pulse
  input wire logic rsp_timeout_o, // Poll gave up
  input wire logic busy_o, // Start-up, access, page or programming pending
  input wire pew_pkg::pew_pins_t pins_o // Memory pins
);
  // ==========
  // Helper state
  localparam int WIN_CYC = (pew_pkg::WINDOW_US * 1000000) / pew_pkg::CLK_PS; // Full window
  int up_ff; // Cycles since reset, saturating
  int gap_ff; // Cycles since the last write strobe fall
  logic open_ff; // A page is being loaded
  logic [6:0] pg_ff; // Upper address of that page
  // Page tracking; a poll read means the page was closed
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      up_ff <= 0;
      gap_ff <= 0;
      open_ff <= 1'b0;
      pg_ff <= 7'h00;
    end else begin
      up_ff <= (up_ff < PWRUP_CYC) ? up_ff + 1 : up_ff;
      gap_ff <= $fell(pins_o.we_n) ? 0 : gap_ff + 1;
      open_ff <= $fell(pins_o.we_n) || (open_ff && pins_o.oe_n);
      pg_ff <= $fell(pins_o.we_n) ? pins_o.addr[10:4] : pg_ff;
    end
  end
  default clocking dc @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // ==========
  // Properties; the reset check cannot be disabled by reset itself
  property p_rst; @(posedge mclk_i) disable iff (1'b0) !rstn_i && $past(!rstn_i) |->
    pins_o.cs_n && pins_o.oe_n && pins_o.we_n && pins_o.dout_oe_n; endproperty
  a_rst: assert property (p_rst) else $error("strobe active in reset");
  property p_pwrup; req_ready_o |-> up_ff >= PWRUP_CYC; endproperty
  a_pwrup: assert property (p_pwrup) else $error("request taken too early");
  property p_rd; !pins_o.oe_n |-> pins_o.we_n && !pins_o.cs_n && pins_o.dout_oe_n; endproperty
  a_rd: assert property (p_rd) else $error("bad read strobes");
  property p_wr; !pins_o.we_n |-> pins_o.oe_n && !pins_o.cs_n && !pins_o.dout_oe_n; endproperty
  a_wr: assert property (p_wr) else $error("bad write strobes");
  property p_addr; !pins_o.we_n |-> $stable(pins_o.addr); endproperty
  a_addr: assert property (p_addr) else $error("address moved in strobe");
  property p_data; $rose(pins_o.we_n) |-> $stable(pins_o.dout) && !pins_o.dout_oe_n; endproperty
  a_data: assert property (p_data) else $error("data moved at strobe rise");
  property p_width; $fell(pins_o.we_n) |-> !pins_o.we_n [*8]; endproperty
  a_width: assert property (p_width) else $error("write strobe too short");
  property p_page; $fell(pins_o.we_n) && open_ff |-> pins_o.addr[10:4] == pg_ff; endproperty
  a_page: assert property (p_page) else $error("page address changed");
  property p_win; $fell(pins_o.we_n) && open_ff |-> gap_ff < WIN_CYC; endproperty
  a_win: assert property (p_win) else $error("page load too late");
  property p_take; req_ready_o |-> req_valid_i && pins_o.we_n && pins_o.oe_n; endproperty
  a_take: assert property (p_take) else $error("request taken mid access");
  property p_tmo; rsp_timeout_o |-> rsp_valid_o; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout without response");
  property p_busy; !pins_o.cs_n |-> busy_o; endproperty
  a_busy: assert property (p_busy) else $error("selected while idle");
  c_page: cover property ($fell(pins_o.we_n) && open_ff);
  c_read: cover property ($fell(pins_o.oe_n));
  c_rsp: cover property (rsp_valid_o);
endmodule : pew_host_props
bind pew_host pew_host_props #(.PWRUP_CYC(PWRUP_CYC)) i_props (.mclk_i(mclk_i),
  .rstn_i(rstn_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
  .rsp_valid_o(rsp_valid_o), .rsp_timeout_o(rsp_timeout_o), .busy_o(busy_o),
  .pins_o(pins_o));

// ===== dv/pew_mem_model.sv
// Purpose: Behavioural byte-wide EEPROM seen from its pins
// Assumes: Times in ns; programming time shortened by PROG_NS
// Notes: viol_o counts host misuse seen on the pins
`timescale 1ns/100ps
module pew_mem_model #(
  parameter int PROG_NS = 40000, // Shortened programming time in ns
  parameter int PWRUP_NS = 5000000 // Start-up time before writes are legal, in ns
) (
  input wire logic cs_n_i, // Chip select, low active
  input wire logic oe_n_i, // Output enable, low active
  input wire logic we_n_i, // Write enable, low active
  input wire logic [10:0] addr_i, // byte_address
  input wire logic [7:0] data_i, // Resolved data_pins
  output logic [7:0] q_o, // Read drive value
  output logic q_oe_n_o, // Low while driving
  output int viol_o // Misuse count
);
  logic [7:0] mem [2048], pg [16], last_d;
  logic [10:0] a_lat, last_a;
  logic [15:0] pg_v = '0;
  logic busy = 1'b0, open = 1'b0;
  int cnt = 0;
  realtime t_fall = 0, t_prog = 0;
  wire wen = cs_n_i | we_n_i; // Write strobe, low only while both are low
  initial viol_o = 0;
  // Address on the later falling strobe
  always @(negedge wen) if (oe_n_i) begin
    a_lat = addr_i;
    if ($realtime < PWRUP_NS) viol_o++;
    t_fall = $realtime;
  end
  // Data on the earlier rising strobe; short glitches and busy writes are dropped
  always @(posedge wen) begin
    if (busy) viol_o++;
    else if (oe_n_i && $realtime - t_fall > 10) begin
      if (open && a_lat[10:4] != last_a[10:4]) viol_o++;
      if (cnt == 16) viol_o++;
      pg[a_lat[3:0]] = data_i;
      pg_v[a_lat[3:0]] = 1'b1;
      last_a = a_lat;
      last_d = data_i;
      open = 1'b1;
      cnt++;
    end
  end
  // Idle window starts programming, which commits the page later
  always #4 begin
    if (open && $realtime - t_fall >= 20000) begin
      open = 1'b0;
      busy = 1'b1;
      t_prog = $realtime;
    end else if (busy && $realtime - t_prog >= PROG_NS) begin
      for (int i = 0; i < 16; i++) if (pg_v[i]) mem[{last_a[10:4], i[3:0]}] = pg[i];
      pg_v = '0;
      busy = 1'b0;
      cnt = 0;
    end
  end
  assign q_oe_n_o = cs_n_i | oe_n_i | ~we_n_i;
  // Pending page counts as programming, so polls see the inverted top bit
  assign q_o = ((busy | open) && addr_i == last_a) ? {~last_d[7], last_d[6:0]} : mem[addr_i];
endmodule : pew_mem_model

// ===== dv/pew_host_tb_top.sv
// Purpose: Self-checking bench for the EEPROM host controller
// Assumes: Start-up wait and programming shortened to keep the run short
// Notes: Driver queues notes, a negedge monitor compares responses
`timescale 1ns/100ps
module pew_host_tb_top;
  `define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
  // ==========
  // Signals
  logic mclk_i, rstn_i, req_valid_i, req_ready_o, rsp_valid_o, rsp_timeout_o, busy_o, q_oe_n;
  logic [7:0] rsp_data_o, q, last_w, exp_mem [2048];
  logic [6:0] base;
  wire [7:0] data_w;
  pew_pkg::pew_req_t req_i;
  pew_pkg::pew_pins_t pins_o;
  logic [8:0] exp_q [$]; // Bit 8 marks a programming-done note
  int err_total, num_checks, viol, cyc = 0;
  integer seed;
  localparam int UP_CYC = 2000; // Shortened start-up wait, host and model agree on it
  // Wire level: host drive, else memory drive, else a float that toggles
  assign data_w = !pins_o.dout_oe_n ? pins_o.dout : (!q_oe_n ? q : ~last_w);
  always @(posedge mclk_i) last_w <= data_w;
  pew_host #(.PWRUP_CYC(UP_CYC)) i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .rsp_timeout_o(rsp_timeout_o), .busy_o(busy_o), .pins_o(pins_o), .data_pins_i(data_w));
  pew_mem_model #(.PWRUP_NS(UP_CYC * pew_pkg::CLK_PS / 1000)) i_mem (.cs_n_i(pins_o.cs_n),
    .oe_n_i(pins_o.oe_n), .we_n_i(pins_o.we_n),
    .addr_i(pins_o.addr), .data_i(data_w), .q_o(q), .q_oe_n_o(q_oe_n), .viol_o(viol));
  task automatic final_report();
    if (err_total == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  // Hang guard: start-up wait plus six programming cycles needs about 50000 cycles
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      final_report();
    end
  end
  // Monitor: settled outputs are looked at on the falling edge
  always @(negedge mclk_i) begin
    if (rsp_valid_o === 1'b1) begin
      if (exp_q.size() == 0) `CHK(rsp_valid_o, 1'b0)
      else begin
        `CHK(rsp_timeout_o, 1'b0)
        if (!exp_q[0][8]) `CHK(rsp_data_o, exp_q[0][7:0])
        void'(exp_q.pop_front());
      end
    end
  end
  // Request held until seen ready before an edge; valid stays up for the next one
  task automatic send(input pew_pkg::pew_cmd_t c, input logic [10:0] a, input logic [7:0] d);
    req_i = '{cmd: c, addr: a, data: d};
    req_valid_i = 1'b1;
    do @(negedge mclk_i); while (req_ready_o !== 1'b1);
    @(posedge mclk_i);
    #1;
  endtask : send
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    send(pew_pkg::PEW_CMD_WRITE, a, d);
    exp_mem[a] = d;
  endtask : wr
  task automatic rd(input logic [10:0] a);
    send(pew_pkg::PEW_CMD_READ, a, 8'h00);
    exp_q.push_back({1'b0, exp_mem[a]});
  endtask : rd
  initial begin
    rstn_i = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    last_w = 8'h00;
    err_total = 0;
    num_checks = 0;
    seed = 32'hfae1;
    repeat (3) @(posedge mclk_i);
    #1 rstn_i = 1'b1;
    // Top address byte write offered at once, then a read that is taken once its programming completes
    wr(11'h7FF, 8'h80);
    exp_q.push_back(9'h100);
    rd(11'h7FF);
    // Full page, then a foreign page write that must close it
    base = 7'($random(seed));
    for (int i = 0; i < 16; i++) wr({base, i[3:0]}, 8'($random(seed)));
    exp_q.push_back(9'h100);
    wr({~base, 4'h0}, 8'h5A);
    exp_q.push_back(9'h100);
    for (int i = 0; i < 16; i++) rd({base, i[3:0]});
    // Seventeen loads in one page spill into a second programming cycle
    for (int i = 0; i < 17; i++) begin
      if (i == 16) exp_q.push_back(9'h100);
      wr({7'h11, i[3:0]}, 8'($random(seed)));
    end
    exp_q.push_back(9'h100);
    for (int i = 0; i < 16; i++) rd({7'h11, i[3:0]});
    // Slow page: second load 10 us after the first still joins it
    wr(11'h3A5, 8'h3C);
    req_valid_i = 1'b0;
    repeat (1250) @(posedge mclk_i);
    #1 wr(11'h3AA, 8'hC3);
    exp_q.push_back(9'h100);
    rd(11'h3A5);
    rd(11'h3AA);
    req_valid_i = 1'b0;
    for (int k = 0; k < 2000 && exp_q.size() > 0; k++) @(posedge mclk_i);
    #1 `CHK(exp_q.size(), 0)
    `CHK(busy_o, 1'b0)
    `CHK(viol, 0)
    final_report();
  end
endmodule : pew_host_tb_top
